// file: rtl/nmpc_map.svh
`ifndef NMPC_MAP_SVH
`define NMPC_MAP_SVH

// command codes
`define NMPC_CMD_PTR_LO      8'h00
`define NMPC_CMD_PTR_HI      8'h01
`define NMPC_CMD_CB_DUMMY    8'h03
`define NMPC_CMD_SETUP       8'h80
`define NMPC_CMD_CONFIRM     8'h10
`define NMPC_CMD_QUEUE       8'h11
`define NMPC_CMD_CB_TARGET   8'h8A
`define NMPC_CMD_RESET       8'hFF

// address layout
`define NMPC_ROW_W           17
`define NMPC_PLANE_LO_BIT    5
`define NMPC_PLANE_HI_BIT    6
`define NMPC_ADDR_CYCLES     4

// timing, in ns and in cycles of sys_clk
`define NMPC_CLK_PERIOD_NS   10
`define NMPC_T_WP_NS         25
`define NMPC_T_WH_NS         15
`define NMPC_T_WB_NS         100
`define NMPC_T_RST_MAX_NS    5000
`define NMPC_WP_CYC   ((`NMPC_T_WP_NS + `NMPC_CLK_PERIOD_NS - 1) / `NMPC_CLK_PERIOD_NS)
`define NMPC_WH_CYC   ((`NMPC_T_WH_NS + `NMPC_CLK_PERIOD_NS - 1) / `NMPC_CLK_PERIOD_NS)
`define NMPC_WB_CYC   ((`NMPC_T_WB_NS + `NMPC_CLK_PERIOD_NS - 1) / `NMPC_CLK_PERIOD_NS)
`define NMPC_RST_MAX_CYC     (`NMPC_T_RST_MAX_NS / `NMPC_CLK_PERIOD_NS)

`endif

// file: rtl/nmpc_pkg.sv
`include "nmpc_map.svh"

package nmpc_pkg;

	typedef enum logic [1:0] {OP_RESET, OP_PROGRAM, OP_COPYBACK} nmpc_op_t;
	typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_DATA} nmpc_kind_t;

	typedef enum logic [3:0] {
		S_IDLE, S_PTR, S_SETUP, S_ADDR, S_DATA, S_MID, S_ADDR2, S_CONFIRM, S_WB, S_WAITRDY
	} nmpc_hstate_t;

	typedef enum logic [1:0] {P_IDLE, P_LOW, P_HIGH} nmpc_phase_t;

	typedef struct packed {
		nmpc_op_t                    op;
		logic                        firstPlane;
		logic                        lastPlane;
		logic                        halfSel;
		logic [7:0]                  col;
		logic [`NMPC_ROW_W-1:0]      srcRow;
		logic [`NMPC_ROW_W-1:0]      dstRow;
	} nmpc_req_t;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       weN;
		logic [7:0] ioOut;
		logic       ioOeN;
	} nmpc_wpins_t;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ceN;
		logic       weN;
		logic       reN;
		logic       wpN;
		logic [7:0] ioOut;
		logic       ioOeN;
	} nmpc_pins_t;

	typedef struct packed {
		nmpc_phase_t phase;
		logic [3:0]  cnt;
		nmpc_wpins_t pins;
		logic        done;
	} nmpc_cyc_s_t;

	typedef struct packed {
		nmpc_hstate_t st;
		nmpc_req_t    rq;
		logic         issued;
		logic         pending;
		logic         holdLast;
		logic         srcDone;
		logic [7:0]   hold;
		logic [1:0]   addrIdx;
		logic [15:0]  cnt;
		logic         reqRdy;
		logic         dataRdy;
		logic         done;
		logic         pErr;
		logic         rTo;
		logic         ceN;
		logic         reN;
		logic         wpN;
	} nmpc_host_s_t;

endpackage : nmpc_pkg

// file: rtl/nmpc_bus_cycle.sv
`include "nmpc_map.svh"

module nmpc_bus_cycle import nmpc_pkg::*; (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// cycle request
	input  wire logic        go,
	input  wire nmpc_kind_t  kind,
	input  wire logic [7:0]  byteVal,
	// flash write pins and completion
	output nmpc_wpins_t      wpins,
	output logic             cycDone
);

	nmpc_cyc_s_t sReg;
	nmpc_cyc_s_t sNext;

	always_comb begin
		sNext = sReg;
		sNext.done = 1'b0;
		case (sReg.phase)
			P_IDLE: begin
				if (go) begin
					sNext.pins.cle   = (kind == CYC_CMD);
					sNext.pins.ale   = (kind == CYC_ADDR);
					sNext.pins.ioOut = byteVal;
					sNext.pins.ioOeN = 1'b0;
					sNext.pins.weN   = 1'b0;
					sNext.cnt        = 4'(`NMPC_WP_CYC - 1);
					sNext.phase      = P_LOW;
				end
			end
			P_LOW: begin
				if (sReg.cnt == 4'h0) begin
					// device latches the byte on this rising edge of the write strobe
					sNext.pins.weN = 1'b1;
					sNext.cnt      = 4'(`NMPC_WH_CYC - 1);
					sNext.phase    = P_HIGH;
				end else begin
					sNext.cnt = sReg.cnt - 4'h1;
				end
			end
			P_HIGH: begin
				if (sReg.cnt == 4'h0) begin
					sNext.pins.cle   = 1'b0;
					sNext.pins.ale   = 1'b0;
					sNext.pins.ioOeN = 1'b1;
					sNext.done       = 1'b1;
					sNext.phase      = P_IDLE;
				end else begin
					sNext.cnt = sReg.cnt - 4'h1;
				end
			end
			default: begin
				sNext.phase = P_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sReg <= '{phase: P_IDLE, cnt: 4'h0,
				pins: '{cle: 1'b0, ale: 1'b0, weN: 1'b1, ioOut: 8'h00, ioOeN: 1'b1},
				done: 1'b0};
		end else begin
			sReg <= sNext;
		end
	end

	assign wpins   = sReg.pins;
	assign cycDone = sReg.done;

endmodule : nmpc_bus_cycle

// file: rtl/nmpc_host.sv
`include "nmpc_map.svh"

// Overview of operation
// - copy-back source and target plane bits must match; host refuses mismatches.
// - single plane: 80h, address, data, 10h; copy-back 00h, 8Ah, 10h.
// - all but the last plane use dummy program 80h ... 11h, loading without programming.
// - dummy copy-back is 03h, 8Ah, then 11h to queue or 10h to start.
module nmpc_host import nmpc_pkg::*; (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// operation request
	input  wire logic        reqValid,
	input  wire nmpc_req_t   req,
	output logic             reqReady,
	// program data stream
	input  wire logic        dataValid,
	input  wire logic [7:0]  dataByte,
	input  wire logic        dataLast,
	output logic             dataReady,
	// status
	output logic             opDone,
	output logic             planeErr,
	output logic             rstTimeout,
	// flash pins
	output nmpc_pins_t       pins,
	input  wire logic [7:0]  ioIn,
	input  wire logic        rdyBusy
);

	nmpc_host_s_t sReg;
	nmpc_host_s_t sNext;
	nmpc_wpins_t  wpins;
	logic         cycDone;
	logic         go;
	logic         emitting;
	nmpc_kind_t   cycKind;
	logic [7:0]   cycByte;
	logic [`NMPC_ROW_W-1:0] curRow;
	logic         planeMismatch;

	nmpc_bus_cycle uCycle (
		.sys_clk (sys_clk),
		.rst     (rst),
		.go      (go),
		.kind    (cycKind),
		.byteVal (cycByte),
		.wpins   (wpins),
		.cycDone (cycDone)
	);

	assign planeMismatch =
		(req.srcRow[`NMPC_PLANE_LO_BIT] != req.dstRow[`NMPC_PLANE_LO_BIT]) ||
		(req.srcRow[`NMPC_PLANE_HI_BIT] != req.dstRow[`NMPC_PLANE_HI_BIT]);

	// byte and kind of the cycle the current state emits
	always_comb begin
		curRow = (sReg.st == S_ADDR2 || sReg.rq.op == OP_PROGRAM) ? sReg.rq.dstRow
			: sReg.rq.srcRow;
		cycKind = CYC_CMD;
		cycByte = 8'h00;
		case (sReg.st)
			S_PTR: begin
				if (sReg.rq.op == OP_COPYBACK) begin
					cycByte = sReg.rq.firstPlane ? `NMPC_CMD_PTR_LO : `NMPC_CMD_CB_DUMMY;
				end else begin
					cycByte = sReg.rq.halfSel ? `NMPC_CMD_PTR_HI : `NMPC_CMD_PTR_LO;
				end
			end
			S_SETUP: begin
				cycByte = `NMPC_CMD_SETUP;
			end
			S_ADDR, S_ADDR2: begin
				cycKind = CYC_ADDR;
				case (sReg.addrIdx)
					2'h0:    cycByte = sReg.rq.col;
					2'h1:    cycByte = curRow[7:0];
					2'h2:    cycByte = curRow[15:8];
					default: cycByte = {7'h00, curRow[16]};
				endcase
			end
			S_DATA: begin
				cycKind = CYC_DATA;
				cycByte = sReg.hold;
			end
			S_MID: begin
				cycByte = `NMPC_CMD_CB_TARGET;
			end
			S_CONFIRM: begin
				if (sReg.rq.op == OP_RESET) begin
					cycByte = `NMPC_CMD_RESET;
				end else begin
					cycByte = sReg.rq.lastPlane ? `NMPC_CMD_CONFIRM : `NMPC_CMD_QUEUE;
				end
			end
			default: begin
				cycByte = 8'h00;
			end
		endcase
		emitting = (sReg.st == S_PTR) || (sReg.st == S_SETUP) || (sReg.st == S_ADDR) ||
			(sReg.st == S_DATA) || (sReg.st == S_MID) || (sReg.st == S_ADDR2) ||
			(sReg.st == S_CONFIRM);
		go = emitting && !sReg.issued && (sReg.st != S_DATA || sReg.pending);
	end

	always_comb begin
		sNext = sReg;
		sNext.done = 1'b0;
		sNext.pErr = 1'b0;
		sNext.dataRdy = 1'b0;
		if (go) begin
			sNext.issued = 1'b1;
		end
		case (sReg.st)
			S_IDLE: begin
				if (reqValid && sReg.reqRdy) begin
					if (req.op == OP_COPYBACK && planeMismatch) begin
						sNext.pErr = 1'b1;
					end else begin
						sNext.rq      = req;
						sNext.rTo     = 1'b0;
						sNext.addrIdx = 2'h0;
						sNext.srcDone = 1'b0;
						sNext.st      = (req.op == OP_RESET) ? S_CONFIRM : S_PTR;
					end
				end
			end
			S_PTR: begin
				if (cycDone) begin
					sNext.issued = 1'b0;
					sNext.st = (sReg.rq.op == OP_COPYBACK) ? S_ADDR : S_SETUP;
				end
			end
			S_SETUP: begin
				if (cycDone) begin
					sNext.issued = 1'b0;
					sNext.st = S_ADDR;
				end
			end
			S_ADDR, S_ADDR2: begin
				if (cycDone) begin
					sNext.issued  = 1'b0;
					sNext.addrIdx = sReg.addrIdx + 2'h1;
					if (sReg.addrIdx == 2'(`NMPC_ADDR_CYCLES - 1)) begin
						sNext.addrIdx = 2'h0;
						if (sReg.st == S_ADDR2) begin
							sNext.st = S_CONFIRM;
						end else if (sReg.rq.op == OP_COPYBACK) begin
							// source page is read into the register before the target code
							sNext.cnt = 16'(`NMPC_WB_CYC - 1);
							sNext.st  = S_WB;
						end else begin
							sNext.st = S_DATA;
						end
					end
				end
			end
			S_DATA: begin
				if (sReg.dataRdy && dataValid) begin
					sNext.hold     = dataByte;
					sNext.holdLast = dataLast;
					sNext.pending  = 1'b1;
				end else begin
					sNext.dataRdy = !sReg.pending && !sReg.issued && !cycDone;
				end
				if (cycDone) begin
					sNext.issued  = 1'b0;
					sNext.pending = 1'b0;
					if (sReg.holdLast) begin
						sNext.st = S_CONFIRM;
					end
				end
			end
			S_MID: begin
				if (cycDone) begin
					sNext.issued = 1'b0;
					sNext.st = S_ADDR2;
				end
			end
			S_CONFIRM: begin
				if (cycDone) begin
					sNext.issued = 1'b0;
					sNext.cnt = 16'(`NMPC_WB_CYC - 1);
					sNext.st = S_WB;
				end
			end
			S_WB: begin
				// ready/busy is not valid until the device has had time to go busy
				if (sReg.cnt == 16'h0000) begin
					sNext.st = S_WAITRDY;
				end else begin
					sNext.cnt = sReg.cnt - 16'h0001;
				end
			end
			S_WAITRDY: begin
				if (rdyBusy) begin
					sNext.cnt = 16'h0000;
					if (sReg.rq.op == OP_COPYBACK && !sReg.srcDone) begin
						sNext.srcDone = 1'b1;
						sNext.st = S_MID;
					end else begin
						sNext.done = 1'b1;
						sNext.st = S_IDLE;
					end
				end else if (sReg.rq.op == OP_RESET) begin
					if (sReg.cnt == 16'(`NMPC_RST_MAX_CYC)) begin
						sNext.rTo = 1'b1;
					end else begin
						sNext.cnt = sReg.cnt + 16'h0001;
					end
				end
			end
			default: begin
				sNext.st = S_IDLE;
			end
		endcase
		sNext.reqRdy = (sNext.st == S_IDLE);
		sNext.ceN    = (sNext.st == S_IDLE);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sReg <= '{st: S_IDLE, rq: '0, issued: 1'b0, pending: 1'b0, holdLast: 1'b0,
				srcDone: 1'b0, hold: 8'h00, addrIdx: 2'h0, cnt: 16'h0000, reqRdy: 1'b1,
				dataRdy: 1'b0, done: 1'b0, pErr: 1'b0, rTo: 1'b0, ceN: 1'b1, reN: 1'b1,
				wpN: 1'b1};
		end else begin
			sReg <= sNext;
		end
	end

	assign reqReady   = sReg.reqRdy;
	assign dataReady  = sReg.dataRdy;
	assign opDone     = sReg.done;
	assign planeErr   = sReg.pErr;
	assign rstTimeout = sReg.rTo;
	assign pins = '{cle: wpins.cle, ale: wpins.ale, ceN: sReg.ceN, weN: wpins.weN,
		reN: sReg.reN, wpN: sReg.wpN, ioOut: wpins.ioOut, ioOeN: wpins.ioOeN};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	plane_refuse_a: assert property (
		reqValid && reqReady && req.op == OP_COPYBACK && planeMismatch
		|=> planeErr && sReg.st == S_IDLE)
		else $error("plane mismatch not refused");
	true_confirm_a: assert property (
		go && sReg.st == S_CONFIRM && sReg.rq.op != OP_RESET && sReg.rq.lastPlane
		|-> cycByte == `NMPC_CMD_CONFIRM)
		else $error("last plane not confirmed with 10h");
	setup_code_a: assert property (
		go && sReg.st == S_SETUP |=> pins.cle && pins.ioOut == `NMPC_CMD_SETUP)
		else $error("setup code not driven");
	dummy_end_a: assert property (
		go && sReg.st == S_CONFIRM && sReg.rq.op != OP_RESET && !sReg.rq.lastPlane
		|=> pins.ioOut == `NMPC_CMD_QUEUE && pins.cle)
		else $error("queued plane not ended with 11h");
	cb_first_a: assert property (
		go && sReg.st == S_PTR && sReg.rq.op == OP_COPYBACK && !sReg.rq.firstPlane
		|-> cycByte == `NMPC_CMD_CB_DUMMY)
		else $error("dummy copy-back not opened with 03h");
	cb_target_a: assert property (
		cycDone && sReg.st == S_MID |=> sReg.st == S_ADDR2 && go && cycKind == CYC_ADDR)
		else $error("target address does not follow 8Ah");
	addr_last_a: assert property (
		go && cycKind == CYC_ADDR && sReg.addrIdx == 2'h3 |=> pins.ale && pins.ioOut[7:1] == 7'h00)
		else $error("upper bits of last address cycle not low");
	half_sel_a: assert property (
		go && sReg.st == S_PTR && sReg.rq.op == OP_PROGRAM
		|-> cycByte == (sReg.rq.halfSel ? `NMPC_CMD_PTR_HI : `NMPC_CMD_PTR_LO))
		else $error("half-page pointer code wrong");
	busy_wait_a: assert property (
		cycDone && sReg.st == S_CONFIRM |=> !go [*8])
		else $error("cycle issued while device may be busy");
	rst_limit_a: assert property (
		sReg.st == S_WAITRDY && sReg.rq.op == OP_RESET && !rdyBusy &&
		sReg.cnt == 16'(`NMPC_RST_MAX_CYC) |=> rstTimeout)
		else $error("reset busy overrun not flagged");

	reset_done_c: cover property (sReg.st == S_WAITRDY && sReg.rq.op == OP_RESET ##1 opDone);
	prog_done_c: cover property (sReg.st == S_WAITRDY && sReg.rq.op == OP_PROGRAM ##1 opDone);
	cb_done_c: cover property (sReg.st == S_WAITRDY && sReg.rq.op == OP_COPYBACK ##1 opDone);
	plane_err_c: cover property (planeErr);

endmodule : nmpc_host

// file: dv/nmpc_flash_model.sv
module nmpc_flash_model import nmpc_pkg::*; (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// flash pins
	input  wire nmpc_pins_t  pins,
	input  wire logic [15:0] busyLen,
	output logic             rdyBusy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] logQ[$];
	logic       weD;
	logic [7:0] lastCmd;
	logic [1:0] srcPl;
	int         addrCnt;
	int         busyCnt;
	int         viol = 0;

	// ready/busy is registered so the host never races the model at the sampling edge
	// bytes are latched on the rising write strobe while selected
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			weD = 1'b1;
			busyCnt = 0;
			addrCnt = 0;
			lastCmd = 8'h00;
			rdyBusy <= 1'b1;
		end else begin
			if (busyCnt > 0)
				busyCnt = busyCnt - 1;
			if (!weD && pins.weN && !pins.ceN) begin
				logQ.push_back({pins.cle, pins.ale, pins.ioOut});
				if (pins.cle) begin
					if (busyCnt > 0)
						viol++;
					lastCmd = pins.ioOut;
					addrCnt = 0;
					if (pins.ioOut == 8'hFF)
						busyCnt = busyLen;
					if (pins.ioOut == 8'h10 || pins.ioOut == 8'h11)
						busyCnt = busyLen;
				end else if (pins.ale && addrCnt < 4) begin
					addrCnt++;
					if (addrCnt == 2 && (lastCmd == 8'h00 || lastCmd == 8'h03))
						srcPl = pins.ioOut[6:5];
					if (addrCnt == 2 && lastCmd == 8'h8A && srcPl != pins.ioOut[6:5])
						viol++;
					if (addrCnt == 4 && pins.ioOut[7:1] != 7'h00)
						viol++;
					if (addrCnt == 4 && (lastCmd == 8'h00 || lastCmd == 8'h03))
						busyCnt = busyLen;
				end
			end
			weD = pins.weN;
			rdyBusy <= (busyCnt == 0);
		end
	end
endmodule : nmpc_flash_model

// file: dv/nmpc_host_tb.sv
module nmpc_host_tb import nmpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk;
	logic        rst = 1'b1;
	logic        reqValid = 1'b0;
	nmpc_req_t   req = '0;
	logic        reqReady;
	logic        dataValid = 1'b0;
	logic [7:0]  dataByte = 8'h00;
	logic        dataLast = 1'b0;
	logic        dataReady;
	logic        opDone;
	logic        planeErr;
	logic        rstTimeout;
	nmpc_pins_t  pins;
	logic        rdyBusy;
	logic [15:0] busyLen = 16'h0014;
	logic [31:0] seed = 32'hA06F76E1;
	logic [9:0]  expQ[$];
	int          err_count = 0;
	int          n_checks = 0;
	nmpc_req_t   r;

	nmpc_host u_dut (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .dataValid(dataValid), .dataByte(dataByte),
		.dataLast(dataLast), .dataReady(dataReady), .opDone(opDone),
		.planeErr(planeErr), .rstTimeout(rstTimeout), .pins(pins),
		.ioIn(8'h00), .rdyBusy(rdyBusy));

	nmpc_flash_model u_flash (.sys_clk(sys_clk), .rst(rst), .pins(pins),
		.busyLen(busyLen), .rdyBusy(rdyBusy));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic ex(input logic [1:0] k, input logic [7:0] b);
		expQ.push_back({k, b});
	endtask : ex

	task automatic addr(input logic [7:0] c, input logic [16:0] row);
		ex(2'b01, c);
		ex(2'b01, row[7:0]);
		ex(2'b01, row[15:8]);
		ex(2'b01, {7'h00, row[16]});
	endtask : addr

	// sends r; unless bad, feeds nd data bytes and waits for completion
	task automatic issue(input int nd, input logic bad);
		int k;
		@(negedge sys_clk);
		reqValid = 1'b1;
		req = r;
		while (reqReady !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		reqValid = 1'b0;
		chk("planeErr", {15'h0, bad}, {15'h0, planeErr});
		chk("reqReady", {15'h0, bad}, {15'h0, reqReady});
		if (!bad) begin
			for (int i = 0; i < nd; i++) begin
				dataValid = 1'b1;
				dataByte = 8'(rnd());
				dataLast = (i == nd - 1);
				ex(2'b00, dataByte);
				while (dataReady !== 1'b1)
					@(negedge sys_clk);
				@(negedge sys_clk);
			end
			dataValid = 1'b0;
			k = 0;
			while (opDone !== 1'b1 && k < 5000) begin
				@(negedge sys_clk);
				k++;
			end
			chk("opDone", 16'h1, {15'h0, opDone});
		end
	endtask : issue

	task automatic cmpLog(input string nm);
		chk("count", 16'(expQ.size()), 16'(u_flash.logQ.size()));
		foreach (expQ[i])
			if (i < u_flash.logQ.size())
				chk("bus", {6'h0, expQ[i]}, {6'h0, u_flash.logQ[i]});
		chk("deviceViol", 16'h0, u_flash.viol[15:0]);
		expQ.delete();
		u_flash.logQ.delete();
		$display("test %s done", nm);
	endtask : cmpLog

	task automatic prog(input logic first, input logic last);
		r = nmpc_req_t'(47'({rnd(), rnd()}));
		r.op = OP_PROGRAM;
		r.firstPlane = first;
		r.lastPlane = last;
		busyLen = 16'd20 + 16'(rnd() % 100);
		ex(2'b10, {7'h00, r.halfSel});
		ex(2'b10, 8'h80);
		addr(r.col, r.dstRow);
		issue(1 + rnd() % 4, 1'b0);
		ex(2'b10, last ? 8'h10 : 8'h11);
		cmpLog("program");
	endtask : prog

	task automatic copyb(input logic first, input logic last, input logic bad);
		r = nmpc_req_t'(47'({rnd(), rnd()}));
		r.op = OP_COPYBACK;
		r.firstPlane = first;
		r.lastPlane = last;
		r.dstRow[6:5] = r.srcRow[6:5] ^ {1'b0, bad};
		busyLen = 16'd20 + 16'(rnd() % 100);
		if (!bad) begin
			ex(2'b10, first ? 8'h00 : 8'h03);
			addr(r.col, r.srcRow);
			ex(2'b10, 8'h8A);
			addr(r.col, r.dstRow);
			ex(2'b10, last ? 8'h10 : 8'h11);
		end
		issue(0, bad);
		cmpLog("copyback");
	endtask : copyb

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	initial begin
		repeat (50000) @(posedge sys_clk);
		err_count++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		chk("idlePins", 16'h1E01, {1'b0, pins});
		chk("reqReady", 16'h1, {15'h0, reqReady});
		for (int s = 0; s < 2; s++) begin
			r = '0;
			r.op = OP_RESET;
			busyLen = s ? 16'd600 : 16'd100;
			ex(2'b10, 8'hFF);
			issue(0, 1'b0);
			chk("rstTimeout", {15'h0, s[0]}, {15'h0, rstTimeout});
			cmpLog("reset");
		end
		prog(1'b1, 1'b1);
		chk("rstTimeout", 16'h0, {15'h0, rstTimeout});
		for (int p = 0; p < 4; p++)
			prog(p == 0, p == 3);
		copyb(1'b1, 1'b1, 1'b0);
		for (int p = 0; p < 4; p++)
			copyb(p == 0, p == 3, 1'b0);
		copyb(1'b1, 1'b1, 1'b1);
		conclude();
	end
endmodule : nmpc_host_tb
